// [host_input_sync.sv]
// Two-stage synchroniser and strobe fall detector for host lines
`timescale 1ns/1ps
`include "spp_port_params.svh"
module host_input_sync (
	input  wire logic   i_clock,
	input  wire logic   i_reset,
	host_sync_if.sync   lines
);
	logic [2:0] strobe_d, strobe_q;
	logic [1:0] dir_d, dir_q;

	// ---------------------------------------------------------------
	// Synchroniser chains
	// ---------------------------------------------------------------
	// First stage feeds only the second; the edge uses stages two and three
	always_comb begin
		strobe_d = {strobe_q[1:0], lines.strobe_raw_n};
		dir_d    = {dir_q[0], lines.dir_raw_n};
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			strobe_q <= {3{`SYNC_RESET}};
			dir_q    <= {2{`SYNC_RESET}};
		end else begin
			strobe_q <= strobe_d;
			dir_q    <= dir_d;
		end
	end

	assign lines.strobe_n    = strobe_q[1];
	assign lines.dir_n       = dir_q[1];
	assign lines.strobe_fall = strobe_q[2] & ~strobe_q[1];

	sync_delay_a: assert property (@(posedge i_clock) disable iff (i_reset)
		##2 lines.strobe_n == $past(lines.strobe_raw_n, 2))
		else $error("strobe synchroniser latency wrong");
endmodule

// [host_port_model.sv]
// Behavioural host controller driving the parallel port pins
`timescale 1ns/1ps
module host_port_model (
	input  wire logic       i_clock,
	input  wire logic       i_busy,
	output logic            o_strobe_n,
	output logic            o_dir_n,
	output logic [7:0]      o_data
);
	// ----------------------------------------------
	// Pin drivers
	// ----------------------------------------------
	logic       drive_q = 1'b0;
	logic [7:0] last_q = 8'h00;
	initial o_strobe_n = 1'b1;
	initial o_dir_n = 1'b1;
	// Released lines show the inverse, so stale data never looks valid
	assign o_data = drive_q ? last_q : ~last_q;

	task automatic set_dir(input logic v);
		@(posedge i_clock);
		o_dir_n <= v;
		if (!v) begin
			drive_q <= 1'b0;
		end
	endtask

	task automatic write_begin(input logic [7:0] b);
		@(posedge i_clock);
		drive_q <= 1'b1;
		last_q <= b;
		repeat (3) @(posedge i_clock);
		for (int i = 0; i < 100 && i_busy; i++) @(posedge i_clock);
		o_strobe_n <= 1'b0;
	endtask

	task automatic strobe_rise();
		@(posedge i_clock);
		o_strobe_n <= 1'b1;
		repeat (3) @(posedge i_clock);
	endtask

	task automatic write_end();
		strobe_rise();
		@(posedge i_clock);
		drive_q <= 1'b0;
	endtask

	task automatic read_ack();
		@(posedge i_clock);
		o_strobe_n <= 1'b0;
	endtask
endmodule

// [host_sync_if.sv]
// Raw and synchronised host control lines
`timescale 1ns/1ps
interface host_sync_if;
	logic strobe_raw_n;
	logic dir_raw_n;
	logic strobe_n;
	logic dir_n;
	logic strobe_fall;
	modport sync (input strobe_raw_n, input dir_raw_n, output strobe_n, output dir_n, output strobe_fall);
	modport user (output strobe_raw_n, output dir_raw_n, input strobe_n, input dir_n, input strobe_fall);
endinterface

// [spp_byte_handshake_port.sv]
// Peripheral end of the standard parallel port byte and nibble handshake
`timescale 1ns/1ps
`include "spp_port_params.svh"
module spp_byte_handshake_port (
	input  wire logic                 i_clock,
	input  wire logic                 i_reset,
	input  wire logic                 i_host_strobe_n,
	input  wire logic                 i_port_direction_ctl_n,
	input  wire logic [`BYTE_W-1:0]   i_host_data_lines,
	input  wire logic                 i_nibble_mode,
	output logic      [`BYTE_W-1:0]   o_host_data_lines,
	output logic                      o_host_data_oe,
	output logic                      o_periph_busy_flag,
	output logic      [`NIB_W-1:0]    o_status_nibble,
	output logic                      o_wr_valid,
	output logic      [`BYTE_W-1:0]   o_wr_data,
	input  wire logic                 i_wr_ack,
	output logic                      o_rd_req,
	input  wire logic                 i_rd_valid,
	input  wire logic [`WORD_W-1:0]   i_rd_data
);
	// Write busy ceiling in clocks: thirteen bus clocks of two clocks each
	localparam int WR_HOLD_MAX = `WR_HOLD_CYC;

	host_sync_if lines ();

	spp_port_pkg::port_state_t state_d, state_q;
	logic [5:0]          t_d, t_q;
	logic [4:0]          hold_d, hold_q;
	logic [1:0]          part_d, part_q;
	logic [`WORD_W-1:0]  word_d, word_q;
	logic [`BYTE_W-1:0]  data_d, data_q, wr_data_d, wr_data_q;
	logic                busy_d, busy_q, oe_d, oe_q, wr_valid_d, wr_valid_q;
	logic                last_part, read_dir;

	// ---------------------------------------------------------------
	// Input synchronisation
	// ---------------------------------------------------------------
	assign lines.strobe_raw_n = i_host_strobe_n;
	assign lines.dir_raw_n    = i_port_direction_ctl_n;

	host_input_sync u_sync (
		.i_clock (i_clock),
		.i_reset (i_reset),
		.lines   (lines)
	);

	// Picks one byte or one nibble out of the fetched 16-bit word
	function automatic logic [`BYTE_W-1:0] pick_part(input logic [`WORD_W-1:0] word,
			input logic [1:0] part, input logic nibble);
		logic [`WORD_W-1:0] sh;
		sh = '0;
		if (nibble) begin
			sh = word >> ({2'h0, part} * 4'h4);
			pick_part = {{(`BYTE_W-`NIB_W){1'b0}}, sh[`NIB_W-1:0]};
		end else begin
			sh = word >> ({2'h0, part} * 4'h8);
			pick_part = sh[`BYTE_W-1:0];
		end
	endfunction

	assign read_dir  = ~lines.dir_n;
	assign last_part = i_nibble_mode ? (part_q == `LAST_NIB_PART) : (part_q == `LAST_BYTE_PART);

	// ---------------------------------------------------------------
	// Handshake sequencer
	// ---------------------------------------------------------------
	// t counts clocks since the strobe pin edge; it saturates at the present point
	always_comb begin
		state_d    = state_q;
		t_d        = (t_q < `T_PRESENT) ? 6'(t_q + 6'h01) : t_q;
		hold_d     = hold_q;
		part_d     = part_q;
		word_d     = word_q;
		data_d     = data_q;
		wr_data_d  = wr_data_q;
		busy_d     = busy_q;
		wr_valid_d = 1'b0;
		// release or drive two to three clocks after the line moves
		// drive start follows the synchronised direction line
		oe_d       = read_dir;
		if (!read_dir && state_q inside {spp_port_pkg::S_RD_FETCH, spp_port_pkg::S_RD_SHOW,
				spp_port_pkg::S_RD_GAP}) begin
			// Direction back to write aborts any read; the fetched word is dropped
			state_d = spp_port_pkg::S_IDLE;
			busy_d  = 1'b0;
			data_d  = `DATA_RESET;
		end else begin
			unique case (state_q)
				spp_port_pkg::S_IDLE: begin
					if (read_dir) begin
						state_d = spp_port_pkg::S_RD_FETCH;
						busy_d  = 1'b1;
						t_d     = `T_PRESENT;
					end else if (lines.strobe_fall) begin
						// Data is sampled while the host still holds it stable
						wr_data_d = i_host_data_lines;
						t_d       = `T_DETECT;
						state_d   = spp_port_pkg::S_WR_PEND;
					end
				end
				spp_port_pkg::S_WR_PEND: begin
					// busy rises eight to nine clocks after strobe
					if (t_q == `T_BUSY_SET) begin
						busy_d     = 1'b1;
						wr_valid_d = 1'b1;
						hold_d     = '0;
						state_d    = spp_port_pkg::S_WR_HOLD;
					end
				end
				spp_port_pkg::S_WR_HOLD: begin
					// busy bounded by thirteen bus clocks
					hold_d = 5'(hold_q + 5'h01);
					if (i_wr_ack || hold_q == `WR_HOLD_LAST) begin
						busy_d  = 1'b0;
						state_d = spp_port_pkg::S_IDLE;
					end
				end
				spp_port_pkg::S_RD_FETCH: begin
					// data and busy fall land on the same edge
					// nibble valid flagged in the same clock
					if (i_rd_valid && t_q == `T_PRESENT) begin
						word_d  = i_rd_data;
						part_d  = '0;
						data_d  = pick_part(i_rd_data, 2'h0, i_nibble_mode);
						busy_d  = 1'b0;
						state_d = spp_port_pkg::S_RD_SHOW;
					end
				end
				spp_port_pkg::S_RD_SHOW: begin
					// no timeout while waiting for the host
					if (lines.strobe_fall) begin
						// byte changes three clocks after strobe
						data_d  = `DATA_RESET;
						t_d     = `T_DETECT;
						state_d = spp_port_pkg::S_RD_GAP;
					end
				end
				spp_port_pkg::S_RD_GAP: begin
					if (last_part && t_q == `T_BUSY_SET) begin
						// word used up, fetch under busy
						busy_d  = 1'b1;
						state_d = spp_port_pkg::S_RD_FETCH;
					end else if (!last_part && t_q == `T_PRESENT) begin
						// six clocks of gap before the next part
						// next byte or nibble from the held word
						part_d  = 2'(part_q + 2'h1);
						data_d  = pick_part(word_q, 2'(part_q + 2'h1), i_nibble_mode);
						state_d = spp_port_pkg::S_RD_SHOW;
					end
				end
			endcase
		end
	end

	// State registers
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			state_q    <= spp_port_pkg::S_IDLE;
			t_q        <= '0;
			hold_q     <= '0;
			part_q     <= '0;
			word_q     <= '0;
			data_q     <= `DATA_RESET;
			wr_data_q  <= `DATA_RESET;
			busy_q     <= 1'b0;
			oe_q       <= 1'b0;
			wr_valid_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			t_q        <= t_d;
			hold_q     <= hold_d;
			part_q     <= part_d;
			word_q     <= word_d;
			data_q     <= data_d;
			wr_data_q  <= wr_data_d;
			busy_q     <= busy_d;
			oe_q       <= oe_d;
			wr_valid_q <= wr_valid_d;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign o_host_data_lines  = data_q;
	assign o_status_nibble    = data_q[`NIB_W-1:0];
	assign o_host_data_oe     = oe_q;
	assign o_periph_busy_flag = busy_q;
	assign o_wr_valid         = wr_valid_q;
	assign o_wr_data          = wr_data_q;
	assign o_rd_req           = (state_q == spp_port_pkg::S_RD_FETCH);

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	sequence busy_after_strobe;
		!o_periph_busy_flag [*6] ##1 o_periph_busy_flag;
	endsequence

	sequence dir_fell_held;
		$fell(i_port_direction_ctl_n) ##1 !i_port_direction_ctl_n [*2];
	endsequence

	sequence dir_rose_held;
		$rose(i_port_direction_ctl_n) ##1 i_port_direction_ctl_n [*2];
	endsequence

	drive_release_a: assert property (@(posedge i_clock) disable iff (i_reset)
		dir_rose_held |=> !o_host_data_oe)
		else $error("data lines not released in time");

	drive_start_a: assert property (@(posedge i_clock) disable iff (i_reset)
		dir_fell_held |=> o_host_data_oe)
		else $error("data lines not driven in time");

	drive_early_a: assert property (@(posedge i_clock) disable iff (i_reset)
		$fell(i_port_direction_ctl_n) && !o_host_data_oe |=> !o_host_data_oe)
		else $error("data lines driven too early");

	write_busy_a: assert property (@(posedge i_clock) disable iff (i_reset)
		state_q == spp_port_pkg::S_IDLE && !read_dir && lines.strobe_fall |-> busy_after_strobe)
		else $error("write busy not at eight to nine clocks");

	write_hold_a: assert property (@(posedge i_clock) disable iff (i_reset)
		$rose(o_periph_busy_flag) && state_q == spp_port_pkg::S_WR_HOLD |-> ##[1:WR_HOLD_MAX] !o_periph_busy_flag)
		else $error("write busy held too long");

	read_ready_a: assert property (@(posedge i_clock) disable iff (i_reset)
		state_q == spp_port_pkg::S_RD_FETCH && read_dir && i_rd_valid && t_q == `T_PRESENT
		|=> !o_periph_busy_flag && o_host_data_lines == pick_part($past(i_rd_data), 2'h0, $past(i_nibble_mode)))
		else $error("busy fall not with read data");

	read_wait_a: assert property (@(posedge i_clock) disable iff (i_reset)
		state_q == spp_port_pkg::S_RD_SHOW && read_dir && !lines.strobe_fall |=> state_q == spp_port_pkg::S_RD_SHOW)
		else $error("read byte withdrawn without strobe");

	fetch_busy_a: assert property (@(posedge i_clock) disable iff (i_reset)
		state_q == spp_port_pkg::S_RD_SHOW && read_dir && last_part && lines.strobe_fall ##1 read_dir [*6]
		|-> o_periph_busy_flag)
		else $error("fetch busy not raised");

	read_hold_a: assert property (@(posedge i_clock) disable iff (i_reset)
		$fell(i_host_strobe_n) && state_q == spp_port_pkg::S_RD_SHOW && read_dir ##1 read_dir [*2]
		|-> $stable(o_host_data_lines))
		else $error("read byte changed too early");

	read_gap_a: assert property (@(posedge i_clock) disable iff (i_reset)
		state_q == spp_port_pkg::S_RD_SHOW && read_dir && !last_part && lines.strobe_fall
		##1 (read_dir && state_q == spp_port_pkg::S_RD_GAP) [*6] |=> state_q == spp_port_pkg::S_RD_SHOW)
		else $error("next read part gap wrong");
endmodule

// [spp_port_params.svh]
// Timing, width and reset constants of the parallel port handshake block
`ifndef SPP_PORT_PARAMS_SVH
`define SPP_PORT_PARAMS_SVH

// ---------------------------------------------------------------
// Clock and bus clock
// ---------------------------------------------------------------
`define CLK_PERIOD_NS     4
`define BCLK_PER_SCLK     2
`define READY_LAG_NS      20
`define READY_LAG_CYC     (`READY_LAG_NS / `CLK_PERIOD_NS)

// ---------------------------------------------------------------
// Handshake timing; t points counted from the strobe pin edge, write hold counted from busy rise
// ---------------------------------------------------------------
`define T_DETECT          6'h03
`define T_BUSY_SET        6'h07
`define T_PRESENT         6'h08
`define WR_HOLD_BCLK      13
`define WR_HOLD_CYC       (`WR_HOLD_BCLK * `BCLK_PER_SCLK)
`define WR_HOLD_LAST      5'((`WR_HOLD_CYC) - 1)

// ---------------------------------------------------------------
// Widths and reset values
// ---------------------------------------------------------------
`define BYTE_W            8
`define WORD_W            16
`define NIB_W             4
`define LAST_BYTE_PART    2'h1
`define LAST_NIB_PART     2'h3
`define DATA_RESET        8'h00
`define SYNC_RESET        1'b1

`endif

// [spp_port_pkg.sv]
// Types shared by the parallel port handshake block
package spp_port_pkg;
	typedef enum logic [2:0] {
		S_IDLE,
		S_WR_PEND,
		S_WR_HOLD,
		S_RD_FETCH,
		S_RD_SHOW,
		S_RD_GAP
	} port_state_t;
endpackage

// [testbench.sv]
// Self-checking bench for the parallel port byte handshake block
`timescale 1ns/1ps
`include "spp_port_params.svh"
module testbench;
	// ----------------------------------------------
	// Clock, reset, wiring
	// ----------------------------------------------
	logic        i_clock = 1'b0;
	logic        i_reset = 1'b1;
	logic        nibble_mode = 1'b0;
	logic        wr_ack = 1'b0;
	logic        rd_valid = 1'b0;
	logic [15:0] rd_data = 16'h0000;
	logic        strobe_n, dir_n, oe, busy, wr_valid, rd_req;
	logic [7:0]  host_data, data_out, wire_data, wr_data;
	logic [3:0]  status;
	int          fails = 0;
	int          checked = 0;
	int          cyc = 0;

	always #2 i_clock = ~i_clock;
	// Pin level: device wins while enabled, else the host's lines
	assign wire_data = oe ? data_out : host_data;

	host_port_model host_u (.i_clock(i_clock), .i_busy(busy), .o_strobe_n(strobe_n), .o_dir_n(dir_n),
		.o_data(host_data));

	spp_byte_handshake_port dut_u (.i_clock(i_clock), .i_reset(i_reset), .i_host_strobe_n(strobe_n),
		.i_port_direction_ctl_n(dir_n), .i_host_data_lines(wire_data), .i_nibble_mode(nibble_mode),
		.o_host_data_lines(data_out), .o_host_data_oe(oe), .o_periph_busy_flag(busy),
		.o_status_nibble(status), .o_wr_valid(wr_valid), .o_wr_data(wr_data), .i_wr_ack(wr_ack),
		.o_rd_req(rd_req), .i_rd_valid(rd_valid), .i_rd_data(rd_data));

	// Cycle count doubles as the hang limit
	always @(posedge i_clock) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails++;
			close_out();
		end
	end

	// ----------------------------------------------
	// Compare and measure helpers
	// ----------------------------------------------
	task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic check_range(input string name, input int lo, input int hi, input int got);
		checked++;
		if (got < lo || got > hi) begin
			fails++;
			$display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, got);
		end
	endtask

	// Edges until busy (0), enable (1) or nonzero data (2) equals v
	task automatic measure(input int which, input logic v, output int n);
		int t0;
		#1;
		t0 = cyc;
		n = 999;
		for (int i = 0; i < 120; i++) begin
			@(posedge i_clock);
			#1;
			if ((which == 0 && busy === v) || (which == 1 && oe === v) ||
				(which == 2 && (data_out !== 8'h00) === v)) begin
				n = cyc - t0;
				break;
			end
		end
	endtask

	// Offers one word; t_seen is the edge at which the first part shows
	task automatic give_word(input logic [15:0] w, output int t_seen);
		int n;
		@(posedge i_clock);
		rd_valid <= 1'b1;
		rd_data <= w;
		measure(0, 1'b0, n);
		t_seen = cyc;
		check_range("rd take", 1, 1, n);
		@(posedge i_clock);
		rd_valid <= 1'b0;
		#1;
	endtask

	// ----------------------------------------------
	// Scenarios
	// ----------------------------------------------
	task automatic t_write(input logic [7:0] b, input logic ack);
		int n;
		int w;
		@(posedge i_clock);
		wr_ack <= ack;
		host_u.write_begin(b);
		measure(0, 1'b1, n);
		// Edges are counted from the edge that lowers the strobe pin
		check_range("wr busy rise", 8, 9, n);
		check_val("wr valid", 16'h0001, 16'(wr_valid));
		check_val("wr data", 16'(b), 16'(wr_data));
		measure(0, 1'b0, w);
		check_val("wr pulse", 16'h0000, 16'(wr_valid));
		check_range("wr busy width", 1, ack ? 2 : `WR_HOLD_CYC, w);
		host_u.write_end();
	endtask

	task automatic t_read(input logic nib, input logic [15:0] w0, input logic [15:0] w1);
		int n;
		int m;
		int t_inv;
		int t_show;
		logic [7:0] e;
		@(posedge i_clock);
		nibble_mode <= nib;
		host_u.set_dir(1'b0);
		measure(1, 1'b1, n);
		check_range("oe on", 2, 3, n);
		check_val("rd entry busy", 16'h0003, 16'({busy, rd_req}));
		give_word(w0, t_show);
		for (int p = 0; p < (nib ? 4 : 2); p++) begin
			e = nib ? 8'(w0[4*p +: 4]) : w0[8*p +: 8];
			check_val("rd part", 16'(e), 16'(data_out));
			check_val("rd status", 16'(e[3:0]), 16'(status));
			check_val("rd busy low", 16'h0000, 16'(busy));
			if (p == 0) begin
				repeat (40) @(posedge i_clock);
				#1;
				check_val("rd wait", 16'(e), 16'(data_out));
			end
			host_u.read_ack();
			measure(2, 1'b0, n);
			check_range("rd hold", 2, 3, n);
			t_inv = cyc;
			if (p < (nib ? 3 : 1)) begin
				measure(2, 1'b1, m);
				check_range("rd next gap", 6, 31, m);
			end else begin
				// Busy is reckoned from the strobe pin edge, n plus m edges back
				measure(0, 1'b1, m);
				check_range("rd fetch busy", 8, 9, n + m);
				repeat (2) @(posedge i_clock);
				#1;
				check_val("rd busy held", 16'h0001, 16'(busy));
				give_word(w1, t_show);
				check_range("rd last gap", 6, 31, t_show - t_inv);
				e = nib ? 8'(w1[3:0]) : w1[7:0];
				check_val("rd next word", 16'(e), 16'(data_out));
			end
			host_u.strobe_rise();
		end
		host_u.set_dir(1'b1);
		measure(1, 1'b0, n);
		check_range("oe off", 2, 3, n);
		check_val("idle busy", 16'h0000, 16'(busy));
		check_val("abort data", 16'h0000, 16'(data_out));
	endtask

	task automatic close_out();
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------------
	// Main sequence
	// ----------------------------------------------
	initial begin
		repeat (10) @(posedge i_clock);
		i_reset <= 1'b0;
		repeat (3) @(posedge i_clock);
		t_write(8'ha5, 1'b1);
		t_write(8'h3c, 1'b0);
		t_read(1'b0, 16'h5a3c, 16'h1e2d);
		t_read(1'b1, 16'h4321, 16'h8765);
		t_write(8'h81, 1'b1);
		close_out();
	end
endmodule
